// ### rtl/atwc_cfg.svh
// constants of the two-wire converter control port
`ifndef ATWC_CFG_SVH
`define ATWC_CFG_SVH
`define ATWC_ADDR_HI 4'hA
`define ATWC_CB_START 7
`define ATWC_CB_SEL_HI 6
`define ATWC_CB_SEL_LO 4
`define ATWC_CB_RNG 3
`define ATWC_CB_BIP 2
`define ATWC_CB_PD1 1
`define ATWC_CB_PD0 0
`define ATWC_CB_RESET 8'h00
`define ATWC_CLK_HZ 100000000
`define ATWC_CONV_HZ 1560000
`define ATWC_CONV_DIV ((`ATWC_CLK_HZ) / (`ATWC_CONV_HZ))
`define ATWC_RES_BITS 12
`endif

// ### rtl/atwc_pkg.sv
// types of the two-wire converter control port
package atwc_pkg;
   typedef enum logic [2:0] {
      ATWC_IDLE, ATWC_ADDR, ATWC_ADDR_ACK, ATWC_CTRL, ATWC_CTRL_ACK,
      ATWC_TX, ATWC_TX_ACK, ATWC_IGNORE
   } atwc_state_t;
   typedef enum logic [1:0] {
      ATWC_PWR_NORMAL, ATWC_PWR_STANDBY, ATWC_PWR_FULL
   } atwc_power_t;
endpackage

// ### rtl/atwc_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module atwc_sync (
   input wire logic clock,
   input wire logic rstn,
   input wire logic din,
   output logic dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule // atwc_sync

// ### rtl/atwc_sar.sv
// successive approximation sequencer
`timescale 1ns/100ps
`include "atwc_cfg.svh"
module atwc_sar #(
   parameter int RES_BITS = `ATWC_RES_BITS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic start,
   input wire logic conv_tick,
   input wire logic comp_above,
   output logic [RES_BITS-1:0] trial,
   output logic busy,
   output logic [RES_BITS-1:0] result
);
   logic [RES_BITS-1:0] bit_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         trial <= '0;
         bit_reg <= '0;
         busy <= 1'b0;
         result <= '0;
      end else if (start) begin
         busy <= 1'b1;
         bit_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
         trial <= {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (busy && conv_tick) begin
         if (bit_reg[0]) begin
            busy <= 1'b0;
            result <= comp_above ? trial : (trial & ~bit_reg);
         end else begin
            trial <= (comp_above ? trial : (trial & ~bit_reg)) | (bit_reg >> 1);
            bit_reg <= bit_reg >> 1;
         end
      end
   end
endmodule // atwc_sar

// ### rtl/atwc_top.sv
// two-wire slave control port of the eight-channel converter
`timescale 1ns/100ps
`include "atwc_cfg.svh"
module atwc_top #(
   parameter logic [3:0] ADDR_HI = `ATWC_ADDR_HI, // value arbitrary
   parameter int RES_BITS = `ATWC_RES_BITS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] addr_select_pins,
   input wire logic power_off_pin,
   input wire logic comp_above,
   output logic [RES_BITS-1:0] dac_trial,
   output logic [2:0] channel_select,
   output logic range_span,
   output logic signed_input_mode,
   output logic track_en,
   output logic conv_busy,
   output logic full_sleep_mode,
   output logic standby_sleep_mode
);
   // ==========================================
   // input synchronisers
   logic scl_s;
   logic sda_s;
   logic scl_d_reg;
   logic sda_d_reg;
   logic pwr_s;
   atwc_sync u_scl (.clock(clock), .rstn(rstn), .din(scl_in), .dout(scl_s));
   atwc_sync u_sda (.clock(clock), .rstn(rstn), .din(sda_in), .dout(sda_s));
   atwc_sync u_pwr (.clock(clock), .rstn(rstn), .din(power_off_pin), .dout(pwr_s));
   logic [2:0] addr_s;
   // one synchroniser per address pin
   for (genvar g = 0; g < 3; g++) begin : g_addr
      atwc_sync u_addr (.clock(clock), .rstn(rstn), .din(addr_select_pins[g]),
         .dout(addr_s[g]));
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   wire scl_rise = scl_s && !scl_d_reg;
   wire scl_fall = !scl_s && scl_d_reg;
   wire start_c = scl_s && scl_d_reg && !sda_s && sda_d_reg;
   wire stop_c = scl_s && scl_d_reg && sda_s && !sda_d_reg;

   // ==========================================
   // bus protocol engine
   atwc_pkg::atwc_state_t state_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic rw_reg;
   logic byte_sel_reg;
   logic ctrl_done_reg;
   logic [7:0] input_control_byte_reg;
   logic [RES_BITS-1:0] result_reg;
   logic sar_busy;
   logic [RES_BITS-1:0] sar_result;
   logic conv_start;
   logic [15:0] tx_word;
   // high byte first, low nibble padded
   assign tx_word = {result_reg, 4'h0};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_reg <= 8'h00;
      end else if (scl_rise) begin
         shift_reg <= {shift_reg[6:0], sda_s};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= atwc_pkg::ATWC_IDLE;
         bit_cnt_reg <= 4'h0;
         rw_reg <= 1'b0;
         byte_sel_reg <= 1'b0;
      end else if (start_c) begin
         state_reg <= atwc_pkg::ATWC_ADDR;
         // start's own clock fall wraps this to zero
         bit_cnt_reg <= 4'hF;
         byte_sel_reg <= 1'b0;
      end else if (stop_c) begin
         state_reg <= atwc_pkg::ATWC_IDLE;
      end else if (scl_fall) begin
         case (state_reg)
            atwc_pkg::ATWC_ADDR: begin
               if (bit_cnt_reg == 4'h7) begin
                  bit_cnt_reg <= 4'h0;
                  rw_reg <= shift_reg[0];
                  if (shift_reg[7:1] == {ADDR_HI, addr_s}) begin
                     state_reg <= atwc_pkg::ATWC_ADDR_ACK;
                  end else begin
                     state_reg <= atwc_pkg::ATWC_IGNORE;
                  end
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            atwc_pkg::ATWC_ADDR_ACK: begin
               state_reg <= rw_reg ? atwc_pkg::ATWC_TX : atwc_pkg::ATWC_CTRL;
            end
            atwc_pkg::ATWC_CTRL: begin
               if (bit_cnt_reg == 4'h0 && !shift_reg[0]) begin
                  state_reg <= atwc_pkg::ATWC_IGNORE;
               end else if (bit_cnt_reg == 4'h7) begin
                  bit_cnt_reg <= 4'h0;
                  state_reg <= atwc_pkg::ATWC_CTRL_ACK;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            atwc_pkg::ATWC_CTRL_ACK: begin
               state_reg <= atwc_pkg::ATWC_IGNORE;
            end
            atwc_pkg::ATWC_TX: begin
               if (bit_cnt_reg == 4'h7) begin
                  bit_cnt_reg <= 4'h0;
                  state_reg <= atwc_pkg::ATWC_TX_ACK;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            atwc_pkg::ATWC_TX_ACK: begin
               // master acknowledge ignored
               if (byte_sel_reg) begin
                  state_reg <= atwc_pkg::ATWC_IGNORE;
               end else begin
                  byte_sel_reg <= 1'b1;
                  state_reg <= atwc_pkg::ATWC_TX;
               end
            end
            atwc_pkg::ATWC_IDLE, atwc_pkg::ATWC_IGNORE: begin
               state_reg <= state_reg;
            end
            default: begin
               state_reg <= atwc_pkg::ATWC_IDLE;
            end
         endcase
      end
   end

   // control byte latch, tracking and conversion request
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         input_control_byte_reg <= `ATWC_CB_RESET;
         ctrl_done_reg <= 1'b0;
         track_en <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (scl_fall && state_reg == atwc_pkg::ATWC_CTRL && bit_cnt_reg == 4'h5
             && pwr_s) begin
            track_en <= 1'b1;
         end
         if (scl_fall && state_reg == atwc_pkg::ATWC_CTRL && bit_cnt_reg == 4'h7) begin
            input_control_byte_reg <= shift_reg;
            ctrl_done_reg <= 1'b1;
         end
         if (start_c) begin
            ctrl_done_reg <= 1'b0;
         end
         if (stop_c && track_en) begin
            track_en <= 1'b0;
            conv_start <= ctrl_done_reg;
            ctrl_done_reg <= 1'b0;
         end else if (stop_c) begin
            ctrl_done_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // open-drain data driver
   // update on falling edge, cleared on start or stop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sda_oe <= 1'b0;
      end else if (start_c || stop_c) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         sda_oe <= 1'b0;
         if (state_reg == atwc_pkg::ATWC_ADDR && bit_cnt_reg == 4'h7
             && shift_reg[7:1] == {ADDR_HI, addr_s}) begin
            sda_oe <= 1'b1;
         end else if (state_reg == atwc_pkg::ATWC_CTRL && bit_cnt_reg == 4'h7) begin
            sda_oe <= 1'b1;
         end else if (state_reg == atwc_pkg::ATWC_ADDR_ACK && rw_reg) begin
            sda_oe <= !tx_word[15];
         end else if (state_reg == atwc_pkg::ATWC_TX && bit_cnt_reg != 4'h7) begin
            sda_oe <= !tx_word[{~byte_sel_reg, 3'h6 - bit_cnt_reg[2:0]}];
         end else if (state_reg == atwc_pkg::ATWC_TX_ACK && !byte_sel_reg) begin
            sda_oe <= !tx_word[7];
         end
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ==========================================
   // conversion clock and converter
   // divider for conversion clock
   logic [7:0] div_reg;
   logic conv_tick;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 8'h00;
         conv_tick <= 1'b0;
      end else if (div_reg == 8'((`ATWC_CONV_DIV) - 1)) begin
         div_reg <= 8'h00;
         conv_tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 8'h01;
         conv_tick <= 1'b0;
      end
   end

   atwc_sar #(.RES_BITS(RES_BITS)) u_sar (
      .clock(clock),
      .rstn(rstn),
      .start(conv_start),
      .conv_tick(conv_tick),
      .comp_above(comp_above),
      .trial(dac_trial),
      .busy(sar_busy),
      .result(sar_result)
   );
   logic sar_busy_d_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sar_busy_d_reg <= 1'b0;
         result_reg <= '0;
         conv_busy <= 1'b0;
      end else begin
         sar_busy_d_reg <= sar_busy;
         conv_busy <= sar_busy || conv_start;
         if (sar_busy_d_reg && !sar_busy) begin
            result_reg <= signed_input_mode ?
               {~sar_result[RES_BITS-1], sar_result[RES_BITS-2:0]} : sar_result;
         end
      end
   end

   // ==========================================
   // mode outputs from the control byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         channel_select <= 3'h0;
         range_span <= 1'b0;
         signed_input_mode <= 1'b0;
      end else begin
         channel_select <= input_control_byte_reg[`ATWC_CB_SEL_HI:`ATWC_CB_SEL_LO];
         range_span <= input_control_byte_reg[`ATWC_CB_RNG];
         signed_input_mode <= input_control_byte_reg[`ATWC_CB_BIP];
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         full_sleep_mode <= 1'b0;
         standby_sleep_mode <= 1'b0;
      end else begin
         full_sleep_mode <= !pwr_s || (input_control_byte_reg[`ATWC_CB_PD1]
            && input_control_byte_reg[`ATWC_CB_PD0] && !sar_busy && !track_en);
         standby_sleep_mode <= pwr_s && input_control_byte_reg[`ATWC_CB_PD1]
            && !input_control_byte_reg[`ATWC_CB_PD0] && !sar_busy && !track_en;
      end
   end
endmodule // atwc_top

// ### verification/atwc_top_properties.sv
// concurrent checks on the converter control port pins
`timescale 1ns/100ps
module atwc_top_properties #(
   parameter int RES_BITS = 12
) (
   input logic clock,
   input logic rstn,
   input logic scl_in,
   input logic sda_in,
   input logic sda_out,
   input logic sda_oe,
   input logic [2:0] addr_select_pins,
   input logic power_off_pin,
   input logic comp_above,
   input logic [RES_BITS-1:0] dac_trial,
   input logic [2:0] channel_select,
   input logic range_span,
   input logic signed_input_mode,
   input logic track_en,
   input logic conv_busy,
   input logic full_sleep_mode,
   input logic standby_sleep_mode
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   logic [11:0] busy_cnt_reg;
   // ====
   // cycles spent converting
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_cnt_reg <= 12'h000;
      end else if (conv_busy) begin
         busy_cnt_reg <= busy_cnt_reg + 12'h001;
      end else begin
         busy_cnt_reg <= 12'h000;
      end
   end
   open_drain_a:
      assert property (sda_out == 1'b0) else $error("data line driven high");
   oe_on_low_a:
      assert property ($rose(sda_oe) |-> !scl_in) else $error("data taken while clock high");
   oe_hold_high_a:
      assert property (scl_in [*6] |-> $stable(sda_oe)) else $error("data moved in clock high");
   track_on_fall_a:
      assert property ($rose(track_en) |-> !scl_in) else $error("tracking began off a fall");
   hold_then_conv_a:
      assert property ($fell(track_en) |-> ##[1:3] conv_busy) else $error("no conversion");
   conv_length_a:
      assert property ($fell(conv_busy) |-> busy_cnt_reg >= 12'h2C0 && busy_cnt_reg <= 12'h340)
      else $error("conversion length wrong");
   trial_in_conv_a:
      assert property ($changed(dac_trial) |-> conv_busy || $past(conv_busy))
      else $error("trial moved while idle");
   setup_held_a:
      assert property (conv_busy && $past(conv_busy) |-> $stable({channel_select, range_span,
         signed_input_mode})) else $error("setup moved in conversion");
   sleep_excl_a:
      assert property (!(full_sleep_mode && standby_sleep_mode)) else $error("two sleep modes");
   pin_sleep_a:
      assert property (!power_off_pin [*8] |-> full_sleep_mode || track_en || conv_busy)
      else $error("power-off pin ignored");
endmodule // atwc_top_properties
bind atwc_top atwc_top_properties #(.RES_BITS(RES_BITS)) i_atwc_top_properties (
   .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .addr_select_pins(addr_select_pins), .power_off_pin(power_off_pin),
   .comp_above(comp_above), .dac_trial(dac_trial), .channel_select(channel_select),
   .range_span(range_span), .signed_input_mode(signed_input_mode), .track_en(track_en),
   .conv_busy(conv_busy), .full_sleep_mode(full_sleep_mode),
   .standby_sleep_mode(standby_sleep_mode));

// ### verification/atwc_master.sv
// two-wire bus master model that drives the serial clock
`timescale 1ns/100ps
module atwc_master (
   output logic scl,
   output logic sda_low,
   input logic sda
);
   // quarter bit times, summing to a 125 ns bit
   localparam realtime QA = 31.2;
   localparam realtime QB = 31.3;
   initial begin
      scl <= 1'b1;
      sda_low <= 1'b0;
   end
   task automatic start();
      sda_low <= 1'b1;
      #(QA + QB) scl <= 1'b0;
   endtask
   task automatic stop();
      #QA sda_low <= 1'b1;
      #QB scl <= 1'b1;
      #QA sda_low <= 1'b0;
      #(2 * (QA + QB));
   endtask
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #QA sda_low <= !tx[i];
         #QB scl <= 1'b1;
         #QA rx[i] = sda;
         #QB scl <= 1'b0;
      end
   endtask
endmodule // atwc_master

// ### verification/atwc_top_tb_top.sv
// self-checking bench of the converter control port
`timescale 1ns/100ps
`define ATWC_CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module atwc_top_tb_top;
   localparam logic [3:0] addr_hi = 4'h6; // value arbitrary
   localparam logic [7:0] waddr = {addr_hi, 3'h5, 1'b0};
   logic clock, rstn, scl, sda_low, sda_out, sda_oe, power_off_pin, comp_above;
   logic range_span, signed_input_mode, track_en, conv_busy, full_sleep_mode, standby_sleep_mode;
   logic [11:0] dac_trial, vin;
   logic [2:0] channel_select, a_pins;
   logic [7:0] ctl;
   logic [1:0] acks;
   logic [15:0] d;
   int n_mismatch = 0;
   int check_count = 0;
   wire sda = !(sda_low || (sda_oe && !sda_out));
   atwc_top #(.ADDR_HI(addr_hi)) i_atwc_top (.clock(clock), .rstn(rstn), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pins(a_pins),
      .power_off_pin(power_off_pin), .comp_above(comp_above), .dac_trial(dac_trial),
      .channel_select(channel_select), .range_span(range_span),
      .signed_input_mode(signed_input_mode), .track_en(track_en), .conv_busy(conv_busy),
      .full_sleep_mode(full_sleep_mode), .standby_sleep_mode(standby_sleep_mode));
   atwc_master i_atwc_master (.scl(scl), .sda_low(sda_low), .sda(sda));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // comparator of the analog input
   always @(negedge clock) comp_above <= (vin >= dac_trial);
   task automatic send_cmd(input logic [7:0] adr, input logic [7:0] c, output logic [1:0] a);
      logic [8:0] rx;
      i_atwc_master.start();
      i_atwc_master.xfer({adr, 1'b1}, rx);
      a[1] = rx[0];
      i_atwc_master.xfer({c, 1'b1}, rx);
      a[0] = rx[0];
   endtask
   task automatic read_res(output logic [15:0] r);
      logic [8:0] rx;
      i_atwc_master.start();
      i_atwc_master.xfer({waddr | 8'h01, 1'b1}, rx);
      `ATWC_CHECK(rx[0], 1'b0)
      i_atwc_master.xfer(9'h1FE, rx);
      r[15:8] = rx[8:1];
      i_atwc_master.xfer(9'h1FF, rx);
      r[7:0] = rx[8:1];
      i_atwc_master.stop();
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (conv_busy === 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      `ATWC_CHECK(conv_busy, 1'b0)
      repeat (6) @(negedge clock);
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      test_done();
   end
   initial begin
      rstn = 1'b0;
      power_off_pin = 1'b1;
      a_pins = 3'h5;
      vin = 12'h000;
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      repeat (10) @(negedge clock);
      `ATWC_CHECK({sda_oe, track_en, conv_busy, full_sleep_mode}, 4'h0)
      power_off_pin = 1'b0;
      repeat (12) @(negedge clock);
      `ATWC_CHECK(full_sleep_mode, 1'b1)
      power_off_pin = 1'b1;
      repeat (12) @(negedge clock);
      `ATWC_CHECK(full_sleep_mode, 1'b0)
      send_cmd(waddr ^ 8'h02, 8'h80, acks);
      `ATWC_CHECK(acks[1], 1'b1)
      i_atwc_master.stop();
      @(negedge clock);
      a_pins = 3'h2;
      send_cmd({addr_hi, 3'h2, 1'b0}, 8'h70, acks);
      `ATWC_CHECK({acks[1], track_en}, 2'b00)
      i_atwc_master.stop();
      repeat (6) @(negedge clock);
      `ATWC_CHECK(conv_busy, 1'b0)
      a_pins = 3'h5;
      for (int i = 0; i < 8; i++) begin
         ctl = {1'b1, 3'(i), 1'(i ^ (i >> 2)), 3'(i >> 2 << 2 | i & 3)};
         vin = 12'(12'h0F1 + i * 12'h1D3);
         send_cmd(waddr, ctl, acks);
         `ATWC_CHECK(acks, 2'b00)
         `ATWC_CHECK(track_en, 1'b1)
         `ATWC_CHECK({channel_select, range_span, signed_input_mode}, ctl[6:2])
         i_atwc_master.stop();
         repeat (4) @(negedge clock);
         `ATWC_CHECK({track_en, conv_busy}, 2'b01)
         wait_idle();
         `ATWC_CHECK({standby_sleep_mode, full_sleep_mode}, {ctl[1] & !ctl[0], ctl[1] & ctl[0]})
         read_res(d);
         `ATWC_CHECK(d, {vin ^ {ctl[2], 11'h000}, 4'h0})
      end
      test_done();
   end
endmodule // atwc_top_tb_top
